// file: hw/sasq_consts.svh
// Shared constants of the converter sequencer and its host.
`ifndef SASQ_CONSTS_SVH
`define SASQ_CONSTS_SVH

`define SASQ_RES 14
`define SASQ_AIN_W 16
`define SASQ_CNT_W 8
`define SASQ_BITS_W 5
`define SASQ_CODE_MAX 16'sh3FFF
`define SASQ_CLK_NS 100
`define SASQ_CNV_FAST_NS 510
`define SASQ_CNV_SLOW_NS 1200
`define SASQ_ACQ_FAST_NS 490
`define SASQ_ACQ_SLOW_NS 800
`define SASQ_QUIET_NS 10
`define SASQ_CNV_FAST_CYC ((`SASQ_CNV_FAST_NS + `SASQ_CLK_NS - 1) / `SASQ_CLK_NS)
`define SASQ_CNV_SLOW_CYC ((`SASQ_CNV_SLOW_NS + `SASQ_CLK_NS - 1) / `SASQ_CLK_NS)
`define SASQ_ACQ_FAST_CYC ((`SASQ_ACQ_FAST_NS + `SASQ_CLK_NS - 1) / `SASQ_CLK_NS)
`define SASQ_ACQ_SLOW_CYC ((`SASQ_ACQ_SLOW_NS + `SASQ_CLK_NS - 1) / `SASQ_CLK_NS)
`define SASQ_QUIET_CYC ((`SASQ_QUIET_NS + `SASQ_CLK_NS - 1) / `SASQ_CLK_NS)
`define SASQ_CAL_CYC 16
`define SASQ_BOOT_CYC 40
`define SASQ_CNV_MARGIN_CYC 4
`define SASQ_SETTLE_CYC 8
`define SASQ_SCLK_HALF_CYC 4
`define SASQ_FIFO_DEPTH 16

`endif

// file: hw/sasq_pkg.sv
// Types shared by the converter end and the host end.
`default_nettype none
`include "sasq_consts.svh"
package sasq_pkg;
  typedef logic [`SASQ_RES-1:0] sasq_code_t;
  typedef logic [`SASQ_CNT_W-1:0] sasq_cnt_t;
  typedef logic [`SASQ_BITS_W-1:0] sasq_bits_t;

  typedef enum logic [1:0] {
    DEV_CAL = 2'b00,
    DEV_ACQ = 2'b01,
    DEV_CONV = 2'b10,
    DEV_WAIT_LOW = 2'b11
  } sasq_dev_state_e;

  typedef enum logic [2:0] {
    HOST_BOOT = 3'b000,
    HOST_ACQ = 3'b001,
    HOST_STROBE = 3'b010,
    HOST_SETTLE = 3'b011,
    HOST_SHIFT_LO = 3'b100,
    HOST_SHIFT_HI = 3'b101,
    HOST_PUSH = 3'b110,
    HOST_QUIET = 3'b111
  } sasq_host_state_e;

  typedef struct packed {
    sasq_dev_state_e state;
    sasq_cnt_t cnt;
    logic cnv_meta;
    logic cnv_sync;
    logic cnv_prev;
    logic clk_meta;
    logic clk_sync;
    logic clk_prev;
    sasq_code_t sample;
    sasq_code_t result;
    sasq_code_t shift;
    sasq_bits_t bits_left;
    logic sdo;
    logic have_result;
  } sasq_dev_s;

  typedef struct packed {
    sasq_host_state_e state;
    sasq_cnt_t cnt;
    sasq_cnt_t acq_t;
    sasq_bits_t bits;
    sasq_code_t word;
    logic sdo_meta;
    logic sdo_sync;
    logic strobe;
    logic sclk;
  } sasq_host_s;
endpackage : sasq_pkg
`default_nettype wire

// file: hw/sasq_link_if.sv
// Three-wire link between the converter and its host.
`default_nettype none
interface sasq_link_if;
  logic conversion_start_strobe;
  logic serial_clk;
  logic serial_data;

  modport device (
    input conversion_start_strobe,
    input serial_clk,
    output serial_data
  );

  modport host (
    output conversion_start_strobe,
    output serial_clk,
    input serial_data
  );
endinterface : sasq_link_if
`default_nettype wire

// file: hw/sasq_device.sv
// Converter end: calibration, input tracking, timed conversion and serial shift-out.
`default_nettype none
`include "sasq_consts.svh"
module sasq_device #(
  parameter bit FAST_GRADE = 1'b1
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  sasq_link_if.device LINK,
  input wire logic signed [`SASQ_AIN_W-1:0] I_ANALOG_IN,
  output sasq_pkg::sasq_dev_state_e O_PHASE,
  output logic O_CALIBRATING,
  output logic O_TRACKING,
  output logic O_CONVERTING,
  output logic O_RESULT_READY,
  output sasq_pkg::sasq_code_t O_LAST_RESULT
);
  import sasq_pkg::*;

  localparam int CNV_CYC_INT = FAST_GRADE ? `SASQ_CNV_FAST_CYC : `SASQ_CNV_SLOW_CYC;
  localparam sasq_cnt_t CNV_LAST = sasq_cnt_t'(CNV_CYC_INT - 1);
  localparam sasq_cnt_t CAL_LAST = sasq_cnt_t'(`SASQ_CAL_CYC - 1);
  localparam sasq_bits_t RES_BITS = sasq_bits_t'(`SASQ_RES);
  localparam sasq_bits_t ONE_BIT = sasq_bits_t'(1);
  localparam sasq_cnt_t CNT_ONE = sasq_cnt_t'(1);

  sasq_dev_s r_reg;
  sasq_dev_s r_next;
  logic cnv_rise;
  logic clk_rise;
  sasq_code_t tracked_code;

  // Straight binary code of the input, pinned at both ends of the range.
  function automatic sasq_code_t clamp_code(input logic signed [`SASQ_AIN_W-1:0] v);
    sasq_code_t c;
    c = '0;
    if (v <= $signed(16'sh0000)) begin
      c = '0;
    end else if (v >= `SASQ_CODE_MAX) begin
      c = '1;
    end else begin
      c = v[`SASQ_RES-1:0];
    end
    return c;
  endfunction

  assign tracked_code = clamp_code(I_ANALOG_IN);

  // Edges are taken from the second synchroniser stage and its delayed copy only.
  assign cnv_rise = r_reg.cnv_sync & ~r_reg.cnv_prev;
  assign clk_rise = r_reg.clk_sync & ~r_reg.clk_prev;

  always_comb begin
    r_next = r_reg;
    r_next.cnv_meta = LINK.conversion_start_strobe;
    r_next.cnv_sync = r_reg.cnv_meta;
    r_next.cnv_prev = r_reg.cnv_sync;
    r_next.clk_meta = LINK.serial_clk;
    r_next.clk_sync = r_reg.clk_meta;
    r_next.clk_prev = r_reg.clk_sync;

    case (r_reg.state)
      DEV_CAL: begin
        // Calibration ignores the link and ends on its own count.
        r_next.cnt = r_reg.cnt + CNT_ONE;
        if (r_reg.cnt == CAL_LAST) begin
          r_next.cnt = '0;
          r_next.state = DEV_ACQ;
        end
      end

      DEV_ACQ: begin
        r_next.sample = tracked_code;
        // Each host clock rise but the 14th moves the next bit onto the data line; the 14th drives it low.
        if (clk_rise && (r_reg.bits_left != '0)) begin
          r_next.shift = {r_reg.shift[`SASQ_RES-2:0], 1'b0};
          r_next.bits_left = r_reg.bits_left - ONE_BIT;
          if (r_reg.bits_left == ONE_BIT) begin
            r_next.sdo = 1'b0;
          end else begin
            r_next.sdo = r_reg.shift[`SASQ_RES-2];
          end
        end
        if (cnv_rise) begin
          // The held sample is the one tracked up to the edge; unread bits are dropped.
          r_next.sample = r_reg.sample;
          r_next.state = DEV_CONV;
          r_next.cnt = '0;
          r_next.bits_left = '0;
          r_next.sdo = 1'b0;
        end
      end

      DEV_CONV: begin
        // Nothing on the link is looked at until the count expires.
        r_next.cnt = r_reg.cnt + CNT_ONE;
        if (r_reg.cnt == CNV_LAST) begin
          r_next.cnt = '0;
          r_next.result = r_reg.sample;
          r_next.have_result = 1'b1;
          r_next.state = DEV_WAIT_LOW;
        end
      end

      DEV_WAIT_LOW: begin
        // The result goes out only once the strobe is seen low.
        if (!r_reg.cnv_sync) begin
          r_next.shift = r_reg.result;
          r_next.sdo = r_reg.result[`SASQ_RES-1];
          r_next.bits_left = RES_BITS;
          r_next.sample = tracked_code;
          r_next.state = DEV_ACQ;
        end
      end

      default: begin
        r_next.state = DEV_CAL;
        r_next.cnt = '0;
      end
    endcase
  end

  // Reset brings the state to calibration with no result and a low data line.
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign LINK.serial_data = r_reg.sdo;
  assign O_PHASE = r_reg.state;
  assign O_CALIBRATING = (r_reg.state == DEV_CAL);
  assign O_TRACKING = (r_reg.state == DEV_ACQ);
  assign O_CONVERTING = (r_reg.state == DEV_CONV);
  assign O_RESULT_READY = r_reg.have_result;
  assign O_LAST_RESULT = r_reg.result;
endmodule : sasq_device
`default_nettype wire

// file: hw/sasq_host.sv
// Host end: strobe and serial clock generation, bit capture and result buffering.
`default_nettype none
`include "sasq_consts.svh"
module sasq_fifo #(
  parameter int WIDTH = `SASQ_RES,
  parameter int DEPTH = `SASQ_FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] PTR_ONE = (AW + 1)'(1);
  localparam logic [AW:0] PTR_DEPTH = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fifo_s;

  fifo_s f_reg;
  fifo_s f_next;

  assign o_ready = (f_reg.wr - f_reg.rd) != PTR_DEPTH;
  assign o_valid = f_reg.wr != f_reg.rd;
  assign o_data = f_reg.mem[f_reg.rd[AW-1:0]];

  always_comb begin
    f_next = f_reg;
    if (i_valid && o_ready) begin
      f_next.mem[f_reg.wr[AW-1:0]] = i_data;
      f_next.wr = f_reg.wr + PTR_ONE;
    end
    if (o_valid && i_ready) begin
      f_next.rd = f_reg.rd + PTR_ONE;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      f_reg <= '0;
    end else begin
      f_reg <= f_next;
    end
  end
endmodule : sasq_fifo

module sasq_host #(
  parameter bit FAST_GRADE = 1'b1
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  sasq_link_if.host LINK,
  input wire logic I_RUN,
  output logic O_WORD_VALID,
  input wire logic I_WORD_READY,
  output sasq_pkg::sasq_code_t O_WORD,
  output sasq_pkg::sasq_host_state_e O_PHASE
);
  import sasq_pkg::*;

  localparam int CNV_CYC_INT = FAST_GRADE ? `SASQ_CNV_FAST_CYC : `SASQ_CNV_SLOW_CYC;
  localparam int ACQ_CYC_INT = FAST_GRADE ? `SASQ_ACQ_FAST_CYC : `SASQ_ACQ_SLOW_CYC;
  localparam sasq_cnt_t STROBE_LAST = sasq_cnt_t'(CNV_CYC_INT + `SASQ_CNV_MARGIN_CYC - 1);
  localparam sasq_cnt_t ACQ_MIN = sasq_cnt_t'(ACQ_CYC_INT);
  localparam sasq_cnt_t BOOT_LAST = sasq_cnt_t'(`SASQ_BOOT_CYC - 1);
  localparam sasq_cnt_t SETTLE_LAST = sasq_cnt_t'(`SASQ_SETTLE_CYC - 1);
  localparam sasq_cnt_t HALF_LAST = sasq_cnt_t'(`SASQ_SCLK_HALF_CYC - 1);
  localparam sasq_cnt_t QUIET_LAST = sasq_cnt_t'(`SASQ_QUIET_CYC - 1);
  localparam sasq_bits_t RES_BITS = sasq_bits_t'(`SASQ_RES);
  localparam sasq_bits_t ONE_BIT = sasq_bits_t'(1);
  localparam sasq_cnt_t CNT_ONE = sasq_cnt_t'(1);

  sasq_host_s h_reg;
  sasq_host_s h_next;
  logic push_valid;
  logic push_ready;

  assign push_valid = (h_reg.state == HOST_PUSH);

  always_comb begin
    h_next = h_reg;
    h_next.sdo_meta = LINK.serial_data;
    h_next.sdo_sync = h_reg.sdo_meta;
    h_next.cnt = h_reg.cnt + CNT_ONE;
    if (h_reg.acq_t != '1) begin
      h_next.acq_t = h_reg.acq_t + CNT_ONE;
    end
    case (h_reg.state)
      HOST_BOOT: begin
        // Waits out the converter's own calibration.
        if (h_reg.cnt == BOOT_LAST) begin
          h_next.cnt = '0;
          h_next.state = HOST_ACQ;
        end
      end
      HOST_ACQ: begin
        // Acquisition lasts until the user runs, the buffer has room and acq_t has reached the minimum acquisition count.
        h_next.cnt = '0;
        if (I_RUN && push_ready && (h_reg.acq_t >= ACQ_MIN)) begin
          h_next.strobe = 1'b1;
          h_next.state = HOST_STROBE;
        end
      end
      HOST_STROBE: begin
        // The link clock stays idle for the whole conversion.
        if (h_reg.cnt == STROBE_LAST) begin
          h_next.strobe = 1'b0;
          h_next.acq_t = '0;
          h_next.cnt = '0;
          h_next.state = HOST_SETTLE;
        end
      end
      HOST_SETTLE: begin
        if (h_reg.cnt == SETTLE_LAST) begin
          h_next.cnt = '0;
          h_next.bits = '0;
          h_next.state = HOST_SHIFT_LO;
        end
      end
      HOST_SHIFT_LO: begin
        if (h_reg.cnt == HALF_LAST) begin
          h_next.cnt = '0;
          h_next.sclk = 1'b1;
          h_next.word = {h_reg.word[`SASQ_RES-2:0], h_reg.sdo_sync};
          h_next.bits = h_reg.bits + ONE_BIT;
          h_next.state = HOST_SHIFT_HI;
        end
      end
      HOST_SHIFT_HI: begin
        if (h_reg.cnt == HALF_LAST) begin
          h_next.cnt = '0;
          h_next.sclk = 1'b0;
          if (h_reg.bits == RES_BITS) begin
            h_next.state = HOST_PUSH;
          end else begin
            h_next.state = HOST_SHIFT_LO;
          end
        end
      end
      HOST_PUSH: begin
        h_next.cnt = '0;
        if (push_ready) begin
          h_next.state = HOST_QUIET;
        end
      end
      HOST_QUIET: begin
        if (h_reg.cnt == QUIET_LAST) begin
          h_next.cnt = '0;
          h_next.state = HOST_ACQ;
        end
      end
      default: begin
        h_next.state = HOST_BOOT;
        h_next.cnt = '0;
      end
    endcase
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      h_reg <= '0;
    end else begin
      h_reg <= h_next;
    end
  end

  sasq_fifo #(
    .WIDTH(`SASQ_RES),
    .DEPTH(`SASQ_FIFO_DEPTH)
  ) u_fifo (
    .i_clk(I_REF_CLK),
    .i_rst(I_RST),
    .i_valid(push_valid),
    .o_ready(push_ready),
    .i_data(h_reg.word),
    .o_valid(O_WORD_VALID),
    .i_ready(I_WORD_READY),
    .o_data(O_WORD)
  );

  assign LINK.conversion_start_strobe = h_reg.strobe;
  assign LINK.serial_clk = h_reg.sclk;
  assign O_PHASE = h_reg.state;
endmodule : sasq_host
`default_nettype wire

// file: tb/sasq_link_monitor.sv
// Checker watching the three-wire link between the converter and its host.
`default_nettype none
`include "sasq_consts.svh"
module sasq_link_monitor #(
  parameter bit FAST_GRADE = 1'b1
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic conversion_start_strobe,
  input wire logic serial_clk,
  input wire logic serial_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // The strobe stands for the grade's conversion count plus the host's margin.
  localparam int STB_CYC = (FAST_GRADE ? `SASQ_CNV_FAST_CYC : `SASQ_CNV_SLOW_CYC) +
    `SASQ_CNV_MARGIN_CYC;
  localparam int ACQ_CYC = FAST_GRADE ? `SASQ_ACQ_FAST_CYC : `SASQ_ACQ_SLOW_CYC;
  localparam logic [4:0] RES_RISES = 5'(`SASQ_RES);
  logic clk_d_reg;
  logic stb_d_reg;
  logic started_reg;
  logic [4:0] rise_cnt_reg;
  logic [7:0] hi_cnt_reg;
  logic [7:0] lo_cnt_reg;
  logic edge_ev;

  // A serial clock rise or a strobe fall is what may move the data line.
  assign edge_ev = (serial_clk & ~clk_d_reg) | (~conversion_start_strobe & stb_d_reg);

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      clk_d_reg <= 1'b0;
      stb_d_reg <= 1'b0;
      started_reg <= 1'b0;
      rise_cnt_reg <= 5'h00;
      hi_cnt_reg <= 8'h00;
      lo_cnt_reg <= 8'h00;
    end else begin
      clk_d_reg <= serial_clk;
      stb_d_reg <= conversion_start_strobe;
      started_reg <= started_reg | conversion_start_strobe;
      rise_cnt_reg <= conversion_start_strobe ? 5'h00 :
        rise_cnt_reg + {4'h0, serial_clk & ~clk_d_reg};
      hi_cnt_reg <= conversion_start_strobe ? hi_cnt_reg + 8'h01 : 8'h00;
      lo_cnt_reg <= (conversion_start_strobe) ? 8'h00 :
        ((lo_cnt_reg == 8'hFF) ? lo_cnt_reg : lo_cnt_reg + 8'h01);
    end
  end

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);

  sequence strobe_rise_s;
    $rose(conversion_start_strobe);
  endsequence
  sequence strobe_fall_s;
    $fell(conversion_start_strobe);
  endsequence

  a_data_strobe_high: assert property (conversion_start_strobe |-> !serial_data)
    else $error("data line driven while strobe high");
  a_no_early_data: assert property (!started_reg |-> !serial_data)
    else $error("data line driven before first conversion");
  a_conv_hold: assert property (strobe_fall_s |-> hi_cnt_reg == STB_CYC)
    else $error("strobe high time wrong");
  a_clock_quiet_conv: assert property (conversion_start_strobe |-> !serial_clk)
    else $error("serial clock active during conversion");
  a_quiet_gap: assert property (strobe_rise_s |-> !$past(serial_clk) && !$past(serial_clk, 2))
    else $error("no quiet gap before strobe rise");
  a_bit_count: assert property (strobe_rise_s |-> rise_cnt_reg == RES_RISES || !started_reg)
    else $error("serial clock count per result wrong");
  a_data_moves_late: assert property ($changed(serial_data) |-> $past(edge_ev, 3))
    else $error("data changed without a clock rise or strobe fall");
  a_acq_min: assert property (strobe_rise_s |-> lo_cnt_reg >= ACQ_CYC)
    else $error("acquisition interval too short");
endmodule // sasq_link_monitor
`default_nettype wire

// file: tb/test_sar_adc_conversion_sequencer.sv
// Bench joining the converter end and the host end across the link.
`default_nettype none
`include "sasq_consts.svh"
module test_sar_adc_conversion_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import sasq_pkg::*;
  logic ref_clk;
  logic rst;
  logic run;
  logic word_ready;
  logic signed [15:0] analog_in;
  sasq_dev_state_e dev_phase;
  sasq_host_state_e host_phase;
  logic calibrating;
  logic tracking;
  logic converting;
  logic result_ready;
  logic word_valid;
  sasq_code_t last_result;
  sasq_code_t word;
  int err_count = 0;
  int checks_done = 0;

  sasq_link_if i_sasq_link_if();
  sasq_device i_sasq_device (.I_REF_CLK(ref_clk), .I_RST(rst), .LINK(i_sasq_link_if),
    .I_ANALOG_IN(analog_in), .O_PHASE(dev_phase), .O_CALIBRATING(calibrating),
    .O_TRACKING(tracking), .O_CONVERTING(converting), .O_RESULT_READY(result_ready),
    .O_LAST_RESULT(last_result));
  sasq_host i_sasq_host (.I_REF_CLK(ref_clk), .I_RST(rst), .LINK(i_sasq_link_if),
    .I_RUN(run), .O_WORD_VALID(word_valid), .I_WORD_READY(word_ready), .O_WORD(word),
    .O_PHASE(host_phase));
  sasq_link_monitor i_sasq_link_monitor (.I_REF_CLK(ref_clk), .I_RST(rst),
    .conversion_start_strobe(i_sasq_link_if.conversion_start_strobe),
    .serial_clk(i_sasq_link_if.serial_clk), .serial_data(i_sasq_link_if.serial_data));

  task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Pops the head word; the stall cycle before the ready pulse keeps the consumer slow.
  task automatic pop_word(input logic [13:0] exp);
    int n;
    for (n = 0; n < 400 && word_valid !== 1'b1; n++) @(negedge ref_clk);
    check_val("word valid", 16'h0001, {15'h0000, word_valid});
    check_val("word", {2'h0, exp}, {2'h0, word});
    @(posedge ref_clk);
    word_ready <= 1'b1;
    @(posedge ref_clk);
    word_ready <= 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic test_boot();
    @(negedge ref_clk);
    check_val("calibrating", 16'h0001, {15'h0000, calibrating});
    check_val("result ready", 16'h0000, {15'h0000, result_ready});
    repeat (20) @(negedge ref_clk);
    check_val("tracking", 16'h0001, {15'h0000, tracking});
    repeat (200) @(negedge ref_clk);
    check_val("still tracking", 16'h0001, {15'h0000, tracking});
    check_val("idle data", 16'h0000, {15'h0000, i_sasq_link_if.serial_data});
    $display("Test boot done");
  endtask

  task automatic test_convert(input logic signed [15:0] ain, input logic [13:0] exp);
    int n;
    @(posedge ref_clk);
    analog_in <= ain;
    run <= 1'b1;
    for (n = 0; n < 400 && converting !== 1'b1; n++) @(negedge ref_clk);
    check_val("conversion started", 16'h0001, {15'h0000, converting});
    @(posedge ref_clk);
    run <= 1'b0;
    analog_in <= ~ain;
    for (n = 0; n < 50 && converting === 1'b1; n++) @(negedge ref_clk);
    check_val("conversion cycles", 16'(`SASQ_CNV_FAST_CYC), 16'(n));
    check_val("last result", {2'h0, exp}, {2'h0, last_result});
    check_val("result ready", 16'h0001, {15'h0000, result_ready});
    check_val("phase wait low", 16'(DEV_WAIT_LOW), 16'(dev_phase));
    for (n = 0; n < 100 && i_sasq_link_if.serial_clk !== 1'b1; n++) @(negedge ref_clk);
    check_val("clock started", 16'h0001, {15'h0000, i_sasq_link_if.serial_clk});
    check_val("tracking in shift", 16'h0001, {15'h0000, tracking});
    pop_word(exp);
    check_val("fifo empty", 16'h0000, {15'h0000, word_valid});
  endtask

  task automatic test_codes();
    logic signed [15:0] ain [7] = '{-16'sh0005, 16'sh0000, 16'sh0001, 16'sh2000,
      16'sh3FFE, 16'sh3FFF, 16'sh7FFF};
    logic [13:0] exp [7] = '{14'h0000, 14'h0000, 14'h0001, 14'h2000, 14'h3FFE,
      14'h3FFF, 14'h3FFF};
    for (int i = 0; i < 7; i++) begin
      test_convert(ain[i], exp[i]);
    end
    $display("Test codes done");
  endtask

  task automatic test_fifo();
    int k;
    logic conv_d;
    k = 0;
    conv_d = 1'b0;
    @(posedge ref_clk);
    analog_in <= 16'sh1555;
    run <= 1'b1;
    for (int n = 0; n < 5000; n++) begin
      @(negedge ref_clk);
      if (converting === 1'b1 && conv_d === 1'b0) begin
        k++;
      end
      conv_d = converting;
    end
    check_val("conversions until full", 16'h0010, 16'(k));
    check_val("host waits", 16'(HOST_ACQ), 16'(host_phase));
    @(posedge ref_clk);
    run <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      pop_word(14'h1555);
    end
    check_val("drained", 16'h0000, {15'h0000, word_valid});
    $display("Test fifo done");
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    give_verdict();
  end

  initial begin
    rst = 1'b1;
    run = 1'b0;
    word_ready = 1'b0;
    analog_in = 16'sh0000;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    test_boot();
    test_codes();
    test_fifo();
    give_verdict();
  end
endmodule // test_sar_adc_conversion_sequencer
`default_nettype wire
